// ### hw/dfps_top.sv
// drive fault and protection supervisor: overload, ground test, phase loss, retry, history
//
// The register addresses and the plain strobed port were decided locally.
module dfps_top #(
    parameter int TICK_CYC = dfps_pkg::MS_CYC,
    parameter int N_OUT = 2,
    parameter bit LARGE_RATING = 1'b1
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire dfps_pkg::dfps_bus_t bus,
    input wire dfps_pkg::dfps_meas_t meas,
    output logic [15:0] rdata_q,
    output logic trip_q,
    output logic phase_drive_q,
    output logic [N_OUT-1:0] term_q
);
    typedef enum logic [1:0] {GT_START, GT_DRIVE, GT_DONE} dfps_gt_t;
    typedef enum logic [1:0] {FS_RUN, FS_WAIT, FS_HOLD} dfps_fs_t;

    logic rst_s1_q, rst_n;
    logic [31:0] tick_cnt_q, tick_cnt_d;
    logic tick_q, tick_d;
    logic [15:0] ctrl_q, ctrl_d, gain_q, gain_d, pw_q, pw_d;
    logic [15:0] retry_q, retry_d, ivl_q, ivl_d, tfunc_q, tfunc_d;
    logic mrst;
    logic [31:0] acc_q, acc_d, cur_x;
    logic ol_en, ol_hi, ol_lo, ol_trip, pre_q, pre_d;
    dfps_gt_t gt_q, gt_d;
    logic [7:0] gt_ms_q, gt_ms_d;
    logic gnd_hit;
    logic ipl_hit, opl_hit;
    logic [7:0] new_code;
    dfps_fs_t fs_q, fs_d;
    logic [6:0] ms_q, ms_d;
    logic [15:0] ds_q, ds_d;
    logic [4:0] used_q, used_d;
    logic accept, fault_clr, fault_sig;
    logic [7:0] code_q [3];
    logic [7:0] code_d [3];
    dfps_pkg::dfps_snap_t snap_q, snap_d;
    logic [15:0] rd_val;
    logic [N_OUT-1:0] term_d;

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    // millisecond tick shared by all timers
    always_comb begin
        tick_d = (tick_cnt_q == 32'(TICK_CYC - 1));
        tick_cnt_d = tick_d ? 32'h0 : tick_cnt_q + 32'h1;
    end

    // settings written by software; out-of-range values are clamped
    always_comb begin
        ctrl_d = ctrl_q;
        gain_d = gain_q;
        pw_d = pw_q;
        retry_d = retry_q;
        ivl_d = ivl_q;
        tfunc_d = tfunc_q;
        mrst = 1'b0;
        if (bus.wr) begin
            unique case (bus.addr)
                dfps_pkg::REG_CTRL: ctrl_d = bus.wdata;
                dfps_pkg::REG_GAIN: gain_d = bus.wdata < dfps_pkg::GAIN_MIN ? dfps_pkg::GAIN_MIN
                    : bus.wdata > dfps_pkg::GAIN_MAX ? dfps_pkg::GAIN_MAX : bus.wdata;
                dfps_pkg::REG_PREWARN: pw_d = bus.wdata < dfps_pkg::PW_MIN ? dfps_pkg::PW_MIN
                    : bus.wdata > dfps_pkg::PW_MAX ? dfps_pkg::PW_MAX : bus.wdata;
                dfps_pkg::REG_RETRY: retry_d = bus.wdata > dfps_pkg::RETRY_MAX
                    ? dfps_pkg::RETRY_MAX : bus.wdata;
                dfps_pkg::REG_IVL: ivl_d = bus.wdata < dfps_pkg::IVL_MIN ? dfps_pkg::IVL_MIN
                    : bus.wdata > dfps_pkg::IVL_MAX ? dfps_pkg::IVL_MAX : bus.wdata;
                dfps_pkg::REG_TFUNC: tfunc_d = bus.wdata;
                dfps_pkg::REG_CMD: mrst = bus.wdata[dfps_pkg::CMD_MRST];
                default: ;
            endcase
        end
    end

    // inverse-time accumulator: heats fast at the high level, slow at the low, cools below
    always_comb begin
        ol_en = ctrl_q[dfps_pkg::CTRL_OL_EN];
        cur_x = 32'(meas.cur) * 32'(dfps_pkg::PCT_FULL);
        ol_hi = cur_x >= 32'(dfps_pkg::OL_HI_PCT) * 32'(gain_q);
        ol_lo = cur_x >= 32'(dfps_pkg::OL_LO_PCT) * 32'(gain_q);
        acc_d = acc_q;
        if (!ol_en || fault_clr) begin
            acc_d = 32'h0;
        end else if (tick_q) begin
            if (ol_hi) begin
                acc_d = acc_q + 32'(dfps_pkg::OL_HI_STEP);
            end else if (ol_lo) begin
                acc_d = acc_q + 32'h1;
            end else if (acc_q != 32'h0) begin
                acc_d = acc_q - 32'h1;
            end
        end
        ol_trip = ol_en && acc_q >= 32'(dfps_pkg::OL_TRIP);
        pre_d = ol_en && acc_q * 32'(dfps_pkg::PCT_FULL)
            >= 32'(dfps_pkg::OL_TRIP) * 32'(pw_q);
    end

    // power-on ground test uses the reset value of the enable; later writes do not rerun it
    always_comb begin
        gt_d = gt_q;
        gt_ms_d = gt_ms_q;
        gnd_hit = 1'b0;
        unique case (gt_q)
            GT_START: gt_d = ctrl_q[dfps_pkg::CTRL_GND_EN] ? GT_DRIVE : GT_DONE;
            GT_DRIVE: begin
                if (meas.gnd_short) begin
                    gnd_hit = 1'b1;
                    gt_d = GT_DONE;
                end else if (tick_q) begin
                    gt_ms_d = gt_ms_q + 8'h1;
                    if (gt_ms_q == 8'(dfps_pkg::GND_TEST_MS - 1)) begin
                        gt_d = GT_DONE;
                    end
                end
            end
            GT_DONE: ;
        endcase
    end

    // phase loss checks and fault priority, lowest code first
    always_comb begin
        ipl_hit = 1'b0;
        if (LARGE_RATING) begin
            unique case (ctrl_q[dfps_pkg::CTRL_IPL_LO +: 2])
                dfps_pkg::IPL_RUN: ipl_hit = meas.in_ploss && meas.running
                    && meas.cur >= 16'(dfps_pkg::IPL_PCT);
                dfps_pkg::IPL_LOSS: ipl_hit = meas.in_ploss;
                default: ipl_hit = 1'b0;
            endcase
        end
        opl_hit = ctrl_q[dfps_pkg::CTRL_OPL_EN] && meas.out_ploss;
        new_code = ol_trip ? dfps_pkg::FC_OL : gnd_hit ? dfps_pkg::FC_GND
            : ipl_hit ? dfps_pkg::FC_IPL : opl_hit ? dfps_pkg::FC_OPL : dfps_pkg::FC_NONE;
    end

    // fault state: wait the interval then retry, or hold once retries are used up
    always_comb begin
        fs_d = fs_q;
        ms_d = ms_q;
        ds_d = ds_q;
        used_d = used_q;
        fault_clr = 1'b0;
        accept = (fs_q == FS_RUN) && (new_code != dfps_pkg::FC_NONE);
        unique case (fs_q)
            FS_RUN: begin
                // a fault beside a manual reset wins, so history and state never disagree
                if (accept) begin
                    fs_d = (16'(used_q) < retry_q) ? FS_WAIT : FS_HOLD;
                    ms_d = 7'h0;
                    ds_d = 16'h0;
                end else if (mrst) begin
                    used_d = 5'h0;
                end
            end
            FS_WAIT: begin
                if (mrst) begin
                    fs_d = FS_RUN;
                    used_d = 5'h0;
                    fault_clr = 1'b1;
                end else if (ds_q == ivl_q) begin
                    fs_d = FS_RUN;
                    used_d = used_q + 5'h1;
                    fault_clr = 1'b1;
                end else if (tick_q) begin
                    ms_d = ms_q + 7'h1;
                    if (ms_q == 7'(dfps_pkg::IVL_UNIT_MS - 1)) begin
                        ms_d = 7'h0;
                        ds_d = ds_q + 16'h1;
                    end
                end
            end
            FS_HOLD: begin
                if (mrst) begin
                    fs_d = FS_RUN;
                    used_d = 5'h0;
                    fault_clr = 1'b1;
                end
            end
            default: fs_d = FS_RUN;
        endcase
        fault_sig = (fs_q == FS_HOLD)
            || (fs_q == FS_WAIT && ctrl_q[dfps_pkg::CTRL_ACT]);
    end

    // history: slot 2 is the latest; a new fault pushes older ones down
    always_comb begin
        code_d = code_q;
        snap_d = snap_q;
        if (accept) begin
            code_d[0] = code_q[1];
            code_d[1] = code_q[2];
            code_d[2] = new_code;
            snap_d.freq = meas.freq;
            snap_d.cur = meas.cur;
            snap_d.vbus = meas.vbus;
            snap_d.mi = {meas.mi[0], meas.mi[9:1]};
        end
    end

    // output terminals, each with its own function nibble
    for (genvar i = 0; i < N_OUT; i++) begin : g_term
        assign term_d[i] = (tfunc_q[4*i +: 4] == dfps_pkg::TF_PREWARN && pre_q)
            || (tfunc_q[4*i +: 4] == dfps_pkg::TF_FAULT && fault_sig);
    end

    // read mux; unmapped indices read zero
    always_comb begin
        unique case (bus.addr)
            dfps_pkg::REG_CTRL: rd_val = ctrl_q;
            dfps_pkg::REG_GAIN: rd_val = gain_q;
            dfps_pkg::REG_PREWARN: rd_val = pw_q;
            dfps_pkg::REG_RETRY: rd_val = retry_q;
            dfps_pkg::REG_IVL: rd_val = ivl_q;
            dfps_pkg::REG_TFUNC: rd_val = tfunc_q;
            dfps_pkg::REG_STATUS: rd_val = {8'h0, used_q, phase_drive_q, pre_q, trip_q};
            dfps_pkg::REG_CODE0: rd_val = {8'h0, code_q[0]};
            dfps_pkg::REG_CODE1: rd_val = {8'h0, code_q[1]};
            dfps_pkg::REG_CODE2: rd_val = {8'h0, code_q[2]};
            dfps_pkg::REG_FREQ: rd_val = snap_q.freq;
            dfps_pkg::REG_CUR: rd_val = snap_q.cur;
            dfps_pkg::REG_VBUS: rd_val = snap_q.vbus;
            dfps_pkg::REG_MI: rd_val = {6'h0, snap_q.mi};
            default: rd_val = 16'h0;
        endcase
    end

    // all state registers except the two reset synchronizer flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= 32'h0;
            tick_q <= 1'b0;
            ctrl_q <= dfps_pkg::CTRL_RST;
            gain_q <= dfps_pkg::GAIN_RST;
            pw_q <= dfps_pkg::PW_RST;
            retry_q <= dfps_pkg::RETRY_RST;
            ivl_q <= dfps_pkg::IVL_RST;
            tfunc_q <= dfps_pkg::TFUNC_RST;
            acc_q <= 32'h0;
            pre_q <= 1'b0;
            gt_q <= GT_START;
            gt_ms_q <= 8'h0;
            fs_q <= FS_RUN;
            ms_q <= 7'h0;
            ds_q <= 16'h0;
            used_q <= 5'h0;
            code_q <= '{default: dfps_pkg::FC_NONE};
            snap_q <= '0;
            rdata_q <= 16'h0;
            trip_q <= 1'b0;
            phase_drive_q <= 1'b0;
            term_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
            tick_q <= tick_d;
            ctrl_q <= ctrl_d;
            gain_q <= gain_d;
            pw_q <= pw_d;
            retry_q <= retry_d;
            ivl_q <= ivl_d;
            tfunc_q <= tfunc_d;
            acc_q <= acc_d;
            pre_q <= pre_d;
            gt_q <= gt_d;
            gt_ms_q <= gt_ms_d;
            fs_q <= fs_d;
            ms_q <= ms_d;
            ds_q <= ds_d;
            used_q <= used_d;
            code_q <= code_d;
            snap_q <= snap_d;
            rdata_q <= bus.rd ? rd_val : 16'h0;
            trip_q <= fs_d != FS_RUN;
            phase_drive_q <= gt_d == GT_DRIVE;
            term_q <= term_d;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence fault_taken_s;
        fs_q == FS_RUN && new_code != dfps_pkg::FC_NONE;
    endsequence

    ol_off_a: assert property (!ol_en |=> acc_q == 32'h0)
        else $error("overload accumulator moved while disabled");
    ol_fast_a: assert property (tick_q && ol_en && ol_hi && !fault_clr
        |=> acc_q == $past(acc_q) + 32'(dfps_pkg::OL_HI_STEP))
        else $error("high overload level did not heat at fast rate");
    ol_slow_a: assert property (tick_q && ol_en && ol_lo && !ol_hi && !fault_clr
        |=> acc_q == $past(acc_q) + 32'h1)
        else $error("low overload level did not heat at slow rate");
    // the last terminal is watched so the index stays in range for any width
    pre_alarm_a: assert property (pre_q
        && tfunc_q[4*(N_OUT-1) +: 4] == dfps_pkg::TF_PREWARN |=> term_q[N_OUT-1])
        else $error("pre-alarm missing on function 6 terminal");
    pw_range_a: assert property (pw_q >= dfps_pkg::PW_MIN && pw_q <= dfps_pkg::PW_MAX)
        else $error("pre-warning coefficient out of range");
    gnd_start_a: assert property (gt_q == GT_START
        |=> phase_drive_q == $past(ctrl_q[dfps_pkg::CTRL_GND_EN]))
        else $error("power-on ground test start wrong");
    retry_hold_a: assert property (fault_taken_s ##0 (16'(used_q) >= retry_q)
        |=> fs_q == FS_HOLD [*2])
        else $error("fault not held after retries used");
    act_quiet_a: assert property (fs_q == FS_WAIT && !ctrl_q[dfps_pkg::CTRL_ACT]
        && tfunc_q[3:0] == dfps_pkg::TF_FAULT && !$changed(ctrl_q) |=> !term_q[0])
        else $error("fault terminal acted during auto reset");
    hist_shift_a: assert property (fault_taken_s |=> code_q[2] == $past(new_code)
        && code_q[1] == $past(code_q[2]) && code_q[0] == $past(code_q[1]))
        else $error("fault history did not shift");
    snap_mi_a: assert property (fault_taken_s
        |=> snap_q.mi == {$past(meas.mi[0]), $past(meas.mi[9:1])})
        else $error("input terminal snapshot order wrong");
endmodule

// ### hw/dfps_pkg.sv
// package for the drive fault and protection supervisor: map, fields, timing, carriers
package dfps_pkg;
    // timing
    localparam int CLK_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int MS_CYC = MS_NS / CLK_NS;
    localparam int GND_TEST_MS = 50;
    localparam int IVL_UNIT_MS = 100;
    localparam int MS_PER_MIN = 60000;
    // inverse-time curve: hi level trips in OL_HI_MIN, lo level in OL_LO_MIN
    localparam int OL_HI_PCT = 195;
    localparam int OL_LO_PCT = 150;
    localparam int OL_HI_MIN = 1;
    localparam int OL_LO_MIN = 5;
    localparam int OL_TRIP = OL_LO_MIN * MS_PER_MIN;
    localparam int OL_HI_STEP = OL_LO_MIN / OL_HI_MIN;
    localparam int PCT_FULL = 100;
    localparam int IPL_PCT = 40;
    // setting limits
    localparam logic [15:0] GAIN_MIN = 16'h0001;
    localparam logic [15:0] GAIN_MAX = 16'h03e8;
    localparam logic [15:0] PW_MIN = 16'h0032;
    localparam logic [15:0] PW_MAX = 16'h0064;
    localparam logic [15:0] RETRY_MAX = 16'h0014;
    localparam logic [15:0] IVL_MIN = 16'h0001;
    localparam logic [15:0] IVL_MAX = 16'h03e8;
    // register indices
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_GAIN = 8'h01;
    localparam logic [7:0] REG_PREWARN = 8'h02;
    localparam logic [7:0] REG_RETRY = 8'h03;
    localparam logic [7:0] REG_IVL = 8'h04;
    localparam logic [7:0] REG_TFUNC = 8'h05;
    localparam logic [7:0] REG_CMD = 8'h06;
    localparam logic [7:0] REG_STATUS = 8'h07;
    localparam logic [7:0] REG_CODE0 = 8'h08;
    localparam logic [7:0] REG_CODE1 = 8'h09;
    localparam logic [7:0] REG_CODE2 = 8'h0a;
    localparam logic [7:0] REG_FREQ = 8'h0b;
    localparam logic [7:0] REG_CUR = 8'h0c;
    localparam logic [7:0] REG_VBUS = 8'h0d;
    localparam logic [7:0] REG_MI = 8'h0e;
    // control fields and reset values
    localparam int CTRL_OL_EN = 0;
    localparam int CTRL_GND_EN = 1;
    localparam int CTRL_IPL_LO = 2;
    localparam int CTRL_OPL_EN = 4;
    localparam int CTRL_ACT = 5;
    localparam int CMD_MRST = 0;
    localparam logic [15:0] CTRL_RST = 16'h0007;
    localparam logic [15:0] GAIN_RST = 16'h0064;
    localparam logic [15:0] PW_RST = 16'h0050;
    localparam logic [15:0] RETRY_RST = 16'h0000;
    localparam logic [15:0] IVL_RST = 16'h003c;
    localparam logic [15:0] TFUNC_RST = 16'h0000;
    localparam logic [1:0] IPL_RUN = 2'h1;
    localparam logic [1:0] IPL_LOSS = 2'h2;
    // output terminal functions
    localparam logic [3:0] TF_FAULT = 4'h2;
    localparam logic [3:0] TF_PREWARN = 4'h6;
    // fault type codes
    localparam logic [7:0] FC_NONE = 8'h00;
    localparam logic [7:0] FC_OL = 8'h01;
    localparam logic [7:0] FC_GND = 8'h02;
    localparam logic [7:0] FC_IPL = 8'h03;
    localparam logic [7:0] FC_OPL = 8'h04;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } dfps_bus_t;

    typedef struct packed {
        logic [15:0] freq;
        logic [15:0] cur;
        logic [15:0] vbus;
        logic running;
        logic in_ploss;
        logic out_ploss;
        logic gnd_short;
        logic [9:0] mi;
    } dfps_meas_t;

    typedef struct packed {
        logic [15:0] freq;
        logic [15:0] cur;
        logic [15:0] vbus;
        logic [9:0] mi;
    } dfps_snap_t;
endpackage

// ### verif/tb_dfps_top.sv
// self-checking bench for the drive fault and protection supervisor
module tb_dfps_top;
    timeunit 1ns;
    timeprecision 1ps;
    // one tick per cycle keeps the minute-long overload curve inside the run
    localparam int TICK = 1;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    dfps_pkg::dfps_bus_t bus = '0;
    dfps_pkg::dfps_meas_t meas = '0;
    logic [15:0] rdata_q;
    logic trip_q;
    logic trip_small;
    logic phase_drive_q;
    logic [1:0] term_q;
    int fails = 0;
    int compares = 0;
    int seed = 34817;
    int n;

    dfps_top #(.TICK_CYC(TICK), .N_OUT(2), .LARGE_RATING(1'b1)) dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .bus(bus), .meas(meas), .rdata_q(rdata_q),
        .trip_q(trip_q), .phase_drive_q(phase_drive_q), .term_q(term_q));

    // small rating variant sees the same traffic but has no input loss check
    dfps_top #(.TICK_CYC(TICK), .N_OUT(2), .LARGE_RATING(1'b0)) dut_small (
        .sys_clk(sys_clk), .arst_n(arst_n), .bus(bus), .meas(meas), .rdata_q(),
        .trip_q(trip_small), .phase_drive_q(), .term_q());

    always #5 sys_clk = ~sys_clk;

    task automatic chk(input string w, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", w, exp, seen);
        end
    endtask

    task automatic chk_rng(input string w, input int v, input int lo, input int hi);
        chk(w, 16'(v >= lo && v <= hi), 16'h0001);
    endtask

    task automatic wrap_up();
        if (fails == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // bus master: strobe for one cycle, signals change only after an edge
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic chk_reg(input logic [7:0] a, input logic [15:0] e, input string w);
        @(posedge sys_clk);
        bus.rd <= 1'b1;
        bus.addr <= a;
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1;
        chk(w, rdata_q, e);
    endtask

    task automatic wr_chk(input logic [7:0] a, input logic [15:0] d, input logic [15:0] e);
        wr_reg(a, d);
        chk_reg(a, e, "clamped setting");
    endtask

    function automatic logic pick(input int which);
        case (which)
            0: return trip_q;
            1: return phase_drive_q;
            default: return term_q[1];
        endcase
    endfunction

    // bounded wait for a level; running out ends the run
    task automatic wait_lvl(input int which, input logic lvl, input int maxc, output int cnt);
        cnt = 0;
        do begin
            @(posedge sys_clk);
            #1;
            cnt++;
        end while (pick(which) !== lvl && cnt < maxc);
        if (pick(which) !== lvl) begin
            fails++;
            $display("MISMATCH wait %0d expected %b seen %b", which, lvl, pick(which));
            wrap_up();
        end
    endtask

    // snapshot word: terminal 0 on top, terminals 1..9 below it
    function automatic logic [15:0] mi_snap(input logic [9:0] mi);
        return {6'h00, mi[0], mi[9:1]};
    endfunction

    task automatic ipl_case(input logic [15:0] c, input logic p, input logic [15:0] cur,
                            input logic e);
        meas.in_ploss <= p;
        meas.running <= 1'b1;
        meas.cur <= cur;
        wr_reg(dfps_pkg::REG_CTRL, c);
        repeat (6) @(posedge sys_clk);
        #1;
        chk("ipl trip", 16'(trip_q), 16'(e));
        chk("small trip", 16'(trip_small), 16'h0000);
        if (e) begin
            chk_reg(dfps_pkg::REG_CODE2, 16'h0003, "ipl code");
        end
        meas.in_ploss <= 1'b0;
        meas.running <= 1'b0;
        wr_reg(dfps_pkg::REG_CMD, 16'h0001);
        wait_lvl(0, 1'b0, 5, n);
    endtask

    initial begin
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        // power-on ground test drives the phases for a while, once
        wait_lvl(1, 1'b1, 10, n);
        wait_lvl(1, 1'b0, 60, n);
        chk_rng("ground test length", n, 48, 52);
        chk_reg(dfps_pkg::REG_CTRL, 16'h0007, "ctrl reset");
        chk_reg(dfps_pkg::REG_PREWARN, 16'h0050, "prewarn reset");
        chk_reg(dfps_pkg::REG_IVL, 16'h003c, "interval reset");
        chk_reg(dfps_pkg::REG_CODE0, 16'h0000, "code0 reset");
        chk_reg(dfps_pkg::REG_CODE2, 16'h0000, "code2 reset");
        chk_reg(8'h20, 16'h0000, "unmapped read");
        wr_chk(dfps_pkg::REG_PREWARN, 16'h001e, 16'h0032);
        wr_chk(dfps_pkg::REG_PREWARN, 16'h0065, 16'h0064);
        wr_chk(dfps_pkg::REG_RETRY, 16'h0015, 16'h0014);
        wr_chk(dfps_pkg::REG_IVL, 16'h0000, 16'h0001);
        // term0 shows the fault, term1 the overload pre-alarm
        wr_reg(dfps_pkg::REG_TFUNC, 16'h0062);
        wr_reg(dfps_pkg::REG_RETRY, 16'h0000);
        wr_reg(dfps_pkg::REG_CTRL, 16'h0000);
        meas.out_ploss <= 1'b1;
        repeat (20) @(posedge sys_clk);
        #1;
        chk("opl off trip", 16'(trip_q), 16'h0000);
        // random snapshots; no retries left so each fault holds
        for (int i = 0; i < 2; i++) begin
            meas.out_ploss <= 1'b0;
            meas.freq <= 16'($random(seed));
            meas.cur <= 16'($random(seed));
            meas.vbus <= 16'($random(seed));
            meas.mi <= 10'($random(seed));
            wr_reg(dfps_pkg::REG_CTRL, 16'h0010);
            meas.out_ploss <= 1'b1;
            wait_lvl(0, 1'b1, 5, n);
            chk_reg(dfps_pkg::REG_CODE2, 16'h0004, "opl code");
            chk_reg(dfps_pkg::REG_CODE1, (i == 0) ? 16'h0000 : 16'h0004, "code1");
            chk_reg(dfps_pkg::REG_FREQ, meas.freq, "snap freq");
            chk_reg(dfps_pkg::REG_CUR, meas.cur, "snap cur");
            chk_reg(dfps_pkg::REG_VBUS, meas.vbus, "snap vbus");
            chk_reg(dfps_pkg::REG_MI, mi_snap(meas.mi), "snap inputs");
            chk("held trip", 16'(trip_q), 16'h0001);
            chk("fault term", 16'(term_q[0]), 16'h0001);
            meas.out_ploss <= 1'b0;
            wr_reg(dfps_pkg::REG_CMD, 16'h0001);
            wait_lvl(0, 1'b0, 5, n);
        end
        ipl_case(16'h0000, 1'b1, 16'h0050, 1'b0);
        ipl_case(16'h0004, 1'b1, 16'h0027, 1'b0);
        ipl_case(16'h0004, 1'b1, 16'h0028, 1'b1);
        ipl_case(16'h0008, 1'b1, 16'h0000, 1'b1);
        chk_reg(dfps_pkg::REG_CODE0, 16'h0004, "code0 shift");
        chk_reg(dfps_pkg::REG_CODE1, 16'h0003, "code1 shift");
        // one retry, quiet terminals, shortest interval; the loss stays on
        wr_reg(dfps_pkg::REG_RETRY, 16'h0001);
        wr_reg(dfps_pkg::REG_CTRL, 16'h0010);
        meas.out_ploss <= 1'b1;
        wait_lvl(0, 1'b1, 5, n);
        repeat (3) @(posedge sys_clk);
        #1;
        chk("quiet term", 16'(term_q[0]), 16'h0000);
        wait_lvl(0, 1'b0, 150, n);
        chk_rng("retry wait", n + 3, 97, 103);
        wait_lvl(0, 1'b1, 5, n);
        repeat (150) @(posedge sys_clk);
        #1;
        chk("retries used trip", 16'(trip_q), 16'h0001);
        chk("hold term", 16'(term_q[0]), 16'h0001);
        // manual reset frees a retry; terminals now act during the wait
        meas.out_ploss <= 1'b0;
        wr_reg(dfps_pkg::REG_CMD, 16'h0001);
        wr_reg(dfps_pkg::REG_CTRL, 16'h0030);
        meas.out_ploss <= 1'b1;
        wait_lvl(0, 1'b1, 5, n);
        repeat (3) @(posedge sys_clk);
        #1;
        chk("action term", 16'(term_q[0]), 16'h0001);
        meas.out_ploss <= 1'b0;
        wait_lvl(0, 1'b0, 150, n);
        chk_rng("auto reset wait", n + 3, 97, 103);
        // overload at the high level of a half gain, lowest pre-warning
        wr_reg(dfps_pkg::REG_CTRL, 16'h0000);
        wr_reg(dfps_pkg::REG_GAIN, 16'h0032);
        wr_reg(dfps_pkg::REG_PREWARN, 16'h0032);
        meas.cur <= 16'h0062;
        wr_reg(dfps_pkg::REG_CTRL, 16'h0001);
        repeat (20000) @(posedge sys_clk);
        // switching off must forget the partial accumulation
        wr_reg(dfps_pkg::REG_CTRL, 16'h0000);
        repeat (50) @(posedge sys_clk);
        #1;
        chk("prealarm off", 16'(term_q[1]), 16'h0000);
        // 5000 ticks at the low level first: +1 each, so the alarm comes 1000 ticks sooner
        meas.cur <= 16'h004b;
        wr_reg(dfps_pkg::REG_CTRL, 16'h0001);
        repeat (5000) @(posedge sys_clk);
        meas.cur <= 16'h0062;
        wait_lvl(2, 1'b1, 30100, n);
        chk_rng("prealarm time", n, 28998, 29006);
        wait_lvl(0, 1'b1, 30100, n);
        chk_rng("overload trip time", n, 29996, 30004);
        chk_reg(dfps_pkg::REG_CODE2, 16'h0001, "overload code");
        // mid-run reset with the phases shorted: the power-on test must catch it
        @(posedge sys_clk);
        arst_n <= 1'b0;
        meas.gnd_short <= 1'b1;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        wait_lvl(0, 1'b1, 10, n);
        chk_rng("ground fault time", n, 4, 4);
        chk_reg(dfps_pkg::REG_CODE2, 16'h0002, "ground code");
        chk_reg(dfps_pkg::REG_CODE1, 16'h0000, "code1 after reset");
        wrap_up();
    end
endmodule
